// ==== rtl/hdres_pkg.sv ====
// Constants, field layout and reset values of the exposure sequencer.
// Assumes one master clock shared by sequencer and controller.
package hdres_pkg;
	// Sequencer register addresses (byte wide, multi-byte values low byte first)
	localparam logic [6:0] A_MONO = 7'h27;
	localparam logic [6:0] A_MODE = 7'h29;
	localparam logic [6:0] A_PRI = 7'h2A;
	localparam logic [6:0] A_STEP = 7'h2D;
	localparam logic [6:0] A_KP1 = 7'h30;
	localparam logic [6:0] A_KP2 = 7'h33;
	localparam logic [6:0] A_SLOPE = 7'h36;
	localparam logic [6:0] A_NFRM = 7'h37;
	localparam logic [6:0] A_SEC = 7'h38;
	localparam logic [6:0] A_FOT = 7'h49;
	localparam logic [6:0] A_CL2 = 7'h59;
	localparam logic [6:0] A_CL3 = 7'h5A;
	// Field positions
	localparam int B_EXT = 0;
	localparam int B_ILV = 1;
	localparam int B_MONO = 0;
	localparam int B_CEN = 6;
	// Reset values
	localparam logic [7:0] R_MONO = 8'h01;
	localparam logic [7:0] R_MODE = 8'h00;
	localparam logic [23:0] R_PRI = 24'h000800;
	localparam logic [23:0] R_STEP = 24'h000000;
	localparam logic [23:0] R_KP = 24'h000001;
	localparam logic [7:0] R_SLOPE = 8'h01;
	localparam logic [7:0] R_NFRM = 8'h01;
	localparam logic [23:0] R_SEC = 24'h000800;
	localparam logic [7:0] R_FOT = 8'h0A;
	localparam logic [7:0] R_CL = 8'h60;
	// Timing: one count unit is 129 master periods; overhead is 0.43*129 per fot unit
	localparam logic [7:0] PRE_LAST = 8'h80;
	localparam logic [20:0] OVH_MUL = 21'h015AB;
	localparam logic [20:0] OVH_DIV = 21'h00064;
	localparam logic [10:0] ROW_LAST = 11'h7FF;
	// Controller register offsets
	localparam logic [2:0] H_ADDR = 3'h0;
	localparam logic [2:0] H_WR = 3'h1;
	localparam logic [2:0] H_RD = 3'h2;
	localparam logic [2:0] H_STAT = 3'h3;
	localparam logic [2:0] H_PINS = 3'h4;
	localparam int H_VALID = 8;
	localparam int H_REFUSED = 9;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_LOAD = 5'h02,
		ST_ARMED = 5'h04,
		ST_EXPOSE = 5'h08,
		ST_READ = 5'h10
	} hdres_state_t;

	// Reset value of one sequencer byte
	function automatic logic [7:0] rst_byte(input logic [6:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == A_MONO) v = R_MONO;
		else if (a == A_MODE) v = R_MODE;
		else if (a == A_PRI + 7'h1) v = R_PRI[15:8];
		else if (a == A_KP1 || a == A_KP2) v = R_KP[7:0];
		else if (a == A_SLOPE) v = R_SLOPE;
		else if (a == A_NFRM) v = R_NFRM;
		else if (a == A_SEC + 7'h1) v = R_SEC[15:8];
		else if (a == A_FOT) v = R_FOT;
		else if (a == A_CL2 || a == A_CL3) v = R_CL;
		return v;
	endfunction : rst_byte

	// Writable bits of one sequencer byte; unmapped bytes read zero
	function automatic logic [7:0] wr_mask(input logic [6:0] a);
		logic [7:0] m;
		m = 8'h00;
		if (a == A_MONO) m = 8'h01;
		else if (a == A_MODE) m = 8'h03;
		else if (a >= A_PRI && a <= A_NFRM + 7'h0) m = (a == A_SLOPE) ? 8'h03 : 8'hFF;
		else if (a >= A_SEC && a <= A_SEC + 7'h2) m = 8'hFF;
		else if (a == A_FOT) m = 8'hFF;
		else if (a == A_CL2 || a == A_CL3) m = 8'h7F;
		return m;
	endfunction : wr_mask

	// Row uses the odd exposure; colour parts pair rows to keep Bayer pairs
	function automatic logic row_odd(input logic [10:0] r, input logic mono);
		return mono ? r[0] : r[1];
	endfunction : row_odd
endpackage : hdres_pkg

// ==== rtl/hdres_link_if.sv ====
// Link between camera controller and exposure sequencer.
// Register port is same-clock logic; pins are asynchronous to the sequencer.
`timescale 1ns/1ps
interface hdres_link_if;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_we;
	logic reg_re;
	logic [7:0] reg_rdata;
	logic frame_req;
	logic exposure_pin_one;
	logic exposure_pin_two;

	modport device (
		input reg_addr, reg_wdata, reg_we, reg_re, frame_req, exposure_pin_one, exposure_pin_two,
		output reg_rdata
	);
	modport host (
		output reg_addr, reg_wdata, reg_we, reg_re, frame_req, exposure_pin_one, exposure_pin_two,
		input reg_rdata
	);
endinterface : hdres_link_if

// ==== rtl/hdres_timer.sv ====
// Interval timer: extra master cycles, then units of 129 master cycles.
// Assumes start and clear come from logic on the same clock.
`timescale 1ns/1ps
module hdres_timer
	import hdres_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	input wire logic i_start,
	input wire logic i_clear,
	input wire logic [23:0] i_units,
	input wire logic [20:0] i_extra,
	output logic o_busy,
	output logic o_done
);
	logic [20:0] extra;
	logic [23:0] units;
	logic [7:0] pre;

	// Last busy cycle when both counts are spent
	assign o_done = o_busy && extra == 21'h0 && units == 24'h0;

	// Overhead cycles first, then prescaled units
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn) begin
			o_busy <= 1'b0;
			extra <= 21'h0;
			units <= 24'h0;
			pre <= 8'h00;
		end else if (i_clk_en) begin
			if (i_start) begin
				o_busy <= 1'b1;
				extra <= i_extra;
				units <= i_units;
				pre <= 8'h00;
			end else if (i_clear || o_done) begin
				o_busy <= 1'b0;
			end else if (o_busy) begin
				if (extra != 21'h0) extra <= extra - 21'h1;
				else if (pre == PRE_LAST) begin
					pre <= 8'h00;
					units <= units - 24'h1;
				end else pre <= pre + 8'h01;
			end
		end
	end
endmodule : hdres_timer

// ==== rtl/hdres_device.sv ====
// Exposure sequencer of the sensor: register file, wide_range_mode timing, readout.
// Assumes the controller drives the register port on this clock; pins are asynchronous.
`timescale 1ns/1ps
//
// Contract
// - Interleave bit gives rows separate exposures
// - Even rows: 129 periods times overhead plus primary
// - Odd rows use the 24-bit secondary count
// - Pin one times even rows, pin two odd
// - Colour parts keep Bayer row pairs together
// - Slope count selects one to three slopes
// - Bright pixels clamped up to twice per exposure
// - First knee interval from knee-one count
// - Second knee interval from knee-two count
// - Clamp byte: enable bit and level code
// - Primary count sets total piecewise exposure
// - Controller never combines piecewise and interleave
// - All modes except burst work internally or pin-timed
// - First burst frame uses primary count
// - Frame n adds n-1 step counts
// - Frame count sets burst length
// - Burst only with register-timed exposure
// - Source bit: registers or pin-to-request timing
// - Overhead term comes from address 73
module hdres_device
	import hdres_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	hdres_link_if.device link,
	output logic o_even_expose,
	output logic o_odd_expose,
	output logic o_clamp_on,
	output logic [5:0] o_clamp_code,
	output logic o_readout,
	output logic [10:0] o_row_index,
	output logic o_row_long,
	output logic [7:0] o_frame_index
);
	logic [7:0] regs [0:127];
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] pin_d;
	hdres_state_t st;
	logic [23:0] l_units;
	logic [23:0] l_step;
	logic [23:0] l_sec;
	logic [23:0] l_k1;
	logic [23:0] l_k2;
	logic [1:0] l_slope;
	logic [6:0] l_cl2;
	logic [6:0] l_cl3;
	logic l_ilv;
	logic l_ext;
	logic l_mono;
	logic [7:0] l_nfrm;
	logic [20:0] l_ovh;
	logic [1:0] knee;
	logic ext_odd;
	logic [10:0] row;
	logic a_busy;
	logic a_done;
	logic b_busy;
	logic b_done;

	// Three-byte field, low byte at the lowest address
	function automatic logic [23:0] get24(input logic [6:0] a);
		return {regs[a + 7'h2], regs[a + 7'h1], regs[a]};
	endfunction : get24

	// Overhead in master cycles: 0.43 * 129 * fot
	function automatic logic [20:0] ovh_cycles(input logic [7:0] f);
		logic [20:0] p;
		p = {13'h0000, f} * OVH_MUL;
		return p / OVH_DIV;
	endfunction : ovh_cycles

	// Live settings and pin edges
	wire cfg_ext = regs[A_MODE][B_EXT];
	wire fr_rise = sync2[0] && !pin_d[0];
	wire p1_rise = sync2[1] && !pin_d[1];
	wire p2_rise = sync2[2] && !pin_d[2];
	wire pwl_one = l_slope >= 2'd2 && l_cl2[B_CEN];
	wire pwl_two = l_slope == 2'd3 && l_cl3[B_CEN];
	wire int_go = st == ST_IDLE && fr_rise && !cfg_ext;
	wire ext_go = st == ST_IDLE && p1_rise && cfg_ext;
	wire last_row = st == ST_READ && row == ROW_LAST;
	wire seq_next = last_row && !l_ext && o_frame_index < l_nfrm;
	wire expo_end = st == ST_EXPOSE && !a_busy && (!b_busy || !l_ilv || l_ext);
	wire ext_win = st == ST_ARMED || (st == ST_EXPOSE && l_ext);

	// Timer starts: main on load (internal) or request edge (pin timed)
	wire a_start = (st == ST_LOAD && !l_ext) || (st == ST_ARMED && fr_rise);
	wire [23:0] a_units = l_ext ? 24'h0 : l_units;
	wire knee_next = b_done && knee == 2'd1 && pwl_two && !l_ilv;
	wire b_start = (st == ST_LOAD && (l_ilv ? !l_ext : pwl_one)) || knee_next;
	wire [23:0] b_units = l_ilv ? l_sec : (knee_next ? l_k2 : l_k1);

	// Next output levels
	wire next_even = (st == ST_EXPOSE && a_busy && !l_ext) || ext_win;
	wire next_odd = !l_ilv ? next_even : (l_ext ? ext_odd && ext_win : st == ST_EXPOSE && b_busy);
	wire next_clamp = knee != 2'd0 && b_busy && next_even;
	wire [5:0] next_code = knee == 2'd2 ? l_cl3[5:0] : l_cl2[5:0];

	// Register file; reads answer one cycle later, unmapped bytes read zero
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn) begin
			for (int i = 0; i < 128; i++) regs[i] <= rst_byte(7'(i));
			link.reg_rdata <= 8'h00;
		end else if (i_clk_en) begin
			if (link.reg_we) regs[link.reg_addr] <= link.reg_wdata & wr_mask(link.reg_addr);
			link.reg_rdata <= link.reg_re ? regs[link.reg_addr] : 8'h00;
		end
	end

	// Pin synchronisers and edge history
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
			pin_d <= 3'h0;
		end else if (i_clk_en) begin
			sync1 <= {link.exposure_pin_two, link.exposure_pin_one, link.frame_req};
			sync2 <= sync1;
			pin_d <= sync2;
		end
	end

	// Frame settings latch and burst step
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn) begin
			l_units <= R_PRI;
			l_step <= R_STEP;
			l_sec <= R_SEC;
			l_k1 <= R_KP;
			l_k2 <= R_KP;
			l_slope <= R_SLOPE[1:0];
			l_cl2 <= R_CL[6:0];
			l_cl3 <= R_CL[6:0];
			l_ilv <= R_MODE[B_ILV];
			l_ext <= R_MODE[B_EXT];
			l_mono <= R_MONO[B_MONO];
			l_nfrm <= R_NFRM;
			l_ovh <= 21'h0;
		end else if (i_clk_en) begin
			if (int_go || ext_go) begin
				l_units <= get24(A_PRI);
				l_step <= get24(A_STEP);
				l_sec <= get24(A_SEC);
				l_k1 <= get24(A_KP1);
				l_k2 <= get24(A_KP2);
				l_slope <= regs[A_SLOPE][1:0];
				l_cl2 <= regs[A_CL2][6:0];
				l_cl3 <= regs[A_CL3][6:0];
				l_ilv <= regs[A_MODE][B_ILV];
				l_ext <= cfg_ext;
				l_mono <= regs[A_MONO][B_MONO];
				l_nfrm <= regs[A_NFRM];
				l_ovh <= ovh_cycles(regs[A_FOT]);
			end else if (seq_next) begin
				l_units <= l_units + l_step;
			end
		end
	end

	// Sequence state, knee phase, pin-two capture, row and frame counters
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn) begin
			st <= ST_IDLE;
			knee <= 2'd0;
			ext_odd <= 1'b0;
			row <= 11'h0;
			o_frame_index <= 8'h00;
		end else if (i_clk_en) begin
			case (st)
				ST_IDLE:
				begin
					ext_odd <= 1'b0;
					o_frame_index <= 8'h00;
					if (int_go || ext_go) st <= ST_LOAD;
				end
				ST_LOAD:
				begin
					o_frame_index <= o_frame_index + 8'h01;
					knee <= (!l_ilv && pwl_one) ? 2'd1 : 2'd0;
					st <= l_ext ? ST_ARMED : ST_EXPOSE;
				end
				ST_ARMED:
				begin
					if (p2_rise) ext_odd <= 1'b1;
					if (fr_rise) st <= ST_EXPOSE;
				end
				ST_EXPOSE:
				begin
					if (knee_next) knee <= 2'd2;
					else if (b_done) knee <= 2'd0;
					if (expo_end) begin
						st <= ST_READ;
						row <= 11'h0;
						knee <= 2'd0;
					end
				end
				ST_READ:
				begin
					row <= row + 11'h1;
					if (seq_next) st <= ST_LOAD;
					else if (last_row) st <= ST_IDLE;
				end
				default: st <= ST_IDLE;
			endcase
		end
	end

	// Registered user outputs
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn) begin
			o_even_expose <= 1'b0;
			o_odd_expose <= 1'b0;
			o_clamp_on <= 1'b0;
			o_clamp_code <= 6'h00;
			o_readout <= 1'b0;
			o_row_index <= 11'h0;
			o_row_long <= 1'b0;
		end else if (i_clk_en) begin
			o_even_expose <= next_even;
			o_odd_expose <= next_odd;
			o_clamp_on <= next_clamp;
			o_clamp_code <= next_code;
			o_readout <= st == ST_READ;
			o_row_index <= row;
			o_row_long <= st == ST_READ && l_ilv && row_odd(row, l_mono);
		end
	end

	// Main exposure timer
	hdres_timer u_tim_a (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_clk_en(i_clk_en),
		.i_start(a_start),
		.i_clear(1'b0),
		.i_units(a_units),
		.i_extra(l_ovh),
		.o_busy(a_busy),
		.o_done(a_done)
	);

	// Odd-row or knee timer; cut short when the exposure ends
	hdres_timer u_tim_b (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_clk_en(i_clk_en),
		.i_start(b_start),
		.i_clear(expo_end),
		.i_units(b_units),
		.i_extra(l_ovh),
		.o_busy(b_busy),
		.o_done(b_done)
	);
endmodule : hdres_device

// ==== rtl/hdres_host.sv ====
// Camera controller end: passes software writes and reads to the sequencer, drives pins.
// Assumes software on the same clock using one-cycle strobes.
`timescale 1ns/1ps
module hdres_host
	import hdres_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	input wire logic [2:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	hdres_link_if.host link
);
	logic [6:0] s_addr;
	logic [7:0] rd_byte;
	logic rd_valid;
	logic refused;
	logic re_d;
	logic sh_ilv;
	logic sh_ext;
	logic [1:0] sh_slope;
	logic [7:0] sh_nfrm;

	// Software strobes
	wire wr_go = i_wr && i_addr == H_WR;
	wire rd_go = i_wr && i_addr == H_RD;
	wire [7:0] d = i_wdata[7:0];
	// Refuse combinations the sequencer does not support
	wire bad_mode = s_addr == A_MODE && ((d[B_ILV] && sh_slope >= 2'd2) || (d[B_EXT] && sh_nfrm > 8'h01));
	wire bad_slope = s_addr == A_SLOPE && d[1:0] >= 2'd2 && sh_ilv;
	wire bad_nfrm = s_addr == A_NFRM && d > 8'h01 && sh_ext;
	wire bad = wr_go && (bad_mode || bad_slope || bad_nfrm);
	wire [15:0] stat = {6'h00, refused, rd_valid, rd_byte};

	// Link strobes and pins
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn) begin
			link.reg_addr <= 7'h00;
			link.reg_wdata <= 8'h00;
			link.reg_we <= 1'b0;
			link.reg_re <= 1'b0;
			link.frame_req <= 1'b0;
			link.exposure_pin_one <= 1'b0;
			link.exposure_pin_two <= 1'b0;
			re_d <= 1'b0;
		end else if (i_clk_en) begin
			link.reg_addr <= s_addr;
			link.reg_wdata <= d;
			link.reg_we <= wr_go && !bad;
			link.reg_re <= rd_go;
			re_d <= link.reg_re;
			if (i_wr && i_addr == H_PINS) begin
				link.frame_req <= i_wdata[0];
				link.exposure_pin_one <= i_wdata[1];
				link.exposure_pin_two <= i_wdata[2];
			end
		end
	end

	// Software registers, shadows of the mode fields, status flags
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn) begin
			s_addr <= 7'h00;
			rd_byte <= 8'h00;
			rd_valid <= 1'b0;
			refused <= 1'b0;
			sh_ilv <= R_MODE[B_ILV];
			sh_ext <= R_MODE[B_EXT];
			sh_slope <= R_SLOPE[1:0];
			sh_nfrm <= R_NFRM;
			o_rdata <= 16'h0000;
		end else if (i_clk_en) begin
			if (i_wr && i_addr == H_ADDR) s_addr <= i_wdata[6:0];
			if (wr_go && !bad && s_addr == A_MODE) begin
				sh_ilv <= d[B_ILV];
				sh_ext <= d[B_EXT];
			end
			if (wr_go && !bad && s_addr == A_SLOPE) sh_slope <= d[1:0];
			if (wr_go && !bad && s_addr == A_NFRM) sh_nfrm <= d;
			if (re_d) rd_byte <= link.reg_rdata;
			if (re_d) rd_valid <= 1'b1;
			else if (rd_go) rd_valid <= 1'b0;
			if (bad) refused <= 1'b1;
			else if (i_wr && i_addr == H_STAT) refused <= 1'b0;
			if (!i_rd) o_rdata <= 16'h0000;
			else if (i_addr == H_ADDR) o_rdata <= {9'h000, s_addr};
			else if (i_addr == H_STAT) o_rdata <= stat;
			else if (i_addr == H_PINS) o_rdata <= {13'h0000, link.exposure_pin_two, link.exposure_pin_one, link.frame_req};
			else o_rdata <= 16'h0000;
		end
	end
endmodule : hdres_host

// ==== bench/hdres_properties.sv ====
// Concurrent checks on the controller-to-sequencer link and on the sequencer outputs.
// Assumes one master clock and a synchronous active-low reset shared by both ends.
`timescale 1ns/1ps
module hdres_properties
	import hdres_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [6:0] reg_addr,
	input wire logic reg_re,
	input wire logic [7:0] reg_rdata,
	input wire logic o_even_expose,
	input wire logic o_clamp_on,
	input wire logic o_readout,
	input wire logic [7:0] o_frame_index
);
	logic [11:0] read_len;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_resetn);

	// Length of the readout pulse now running
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn || !o_readout)
			read_len <= 12'h000;
		else
			read_len <= read_len + 12'h001;
	end

	// Read launch at one sequencer address
	sequence s_rd(logic [6:0] a);
		reg_re && reg_addr == a;
	endsequence

	property p_mode_mask;
		s_rd(A_MODE) |=> reg_rdata[7:2] == 6'h00;
	endproperty
	property p_mono_mask;
		s_rd(A_MONO) |=> reg_rdata[7:1] == 7'h00;
	endproperty
	property p_slope_mask;
		s_rd(A_SLOPE) |=> reg_rdata[7:2] == 6'h00;
	endproperty
	property p_clamp_mask;
		(s_rd(A_CL2) or s_rd(A_CL3)) |=> reg_rdata[7] == 1'b0;
	endproperty
	property p_unmapped;
		s_rd(7'h3B) |=> reg_rdata == 8'h00;
	endproperty
	property p_rdata_idle;
		!reg_re |=> reg_rdata == 8'h00;
	endproperty
	property p_clamp_in_expose;
		$rose(o_clamp_on) |-> ##[0:1] o_even_expose;
	endproperty
	property p_readout_len;
		$fell(o_readout) |-> read_len == 12'h800;
	endproperty
	property p_expose_index;
		o_even_expose |-> o_frame_index != 8'h00;
	endproperty

	a_mode_mask: assert property (p_mode_mask) else $error("mode byte shows extra bits");
	a_mono_mask: assert property (p_mono_mask) else $error("sensor type byte shows extra bits");
	a_slope_mask: assert property (p_slope_mask) else $error("slope byte shows extra bits");
	a_clamp_mask: assert property (p_clamp_mask) else $error("clamp byte shows bit 7");
	a_unmapped: assert property (p_unmapped) else $error("unmapped byte not zero");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
	a_clamp_in_expose: assert property (p_clamp_in_expose) else $error("clamp outside exposure");
	a_readout_len: assert property (p_readout_len) else $error("readout length wrong");
	a_expose_index: assert property (p_expose_index) else $error("exposure with no frame number");
endmodule : hdres_properties

// ==== bench/hdres_exposure_sequencer_tb.sv ====
// Self-checking bench: software port of the controller, sequencer outputs observed.
// Assumes a 10 MHz master clock and overhead byte set to 1, so one overhead term is 55 cycles.
`timescale 1ns/1ps
module hdr_exposure_sequencer_tb
	import hdres_pkg::*;
;
	logic i_ref_clk, i_resetn, i_clk_en, i_wr, i_rd;
	logic [2:0] i_addr;
	logic [15:0] i_wdata, o_rdata, v;
	logic o_even_expose, o_odd_expose, o_clamp_on, o_readout, o_row_long;
	logic [5:0] o_clamp_code;
	logic [10:0] o_row_index;
	logic [7:0] o_frame_index, d;
	logic [3:0] mon;
	int bad_count, checks, w0, w1, w2;
	logic [15:0] rst_tab [20] = '{16'h2701, 16'h2900, 16'h2A00, 16'h2B08, 16'h2C00, 16'h2D00, 16'h2E00,
		16'h2F00, 16'h3001, 16'h3100, 16'h3301, 16'h3601, 16'h3701, 16'h3800, 16'h3908, 16'h3A00,
		16'h490A, 16'h5960, 16'h5A60, 16'h3B00};

	assign mon = {o_readout, o_clamp_on, o_odd_expose, o_even_expose};

	hdres_link_if link();
	hdres_host u_hdres_host (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(link));
	hdres_device u_hdres_device (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en), .link(link),
		.o_even_expose(o_even_expose), .o_odd_expose(o_odd_expose), .o_clamp_on(o_clamp_on),
		.o_clamp_code(o_clamp_code), .o_readout(o_readout), .o_row_index(o_row_index),
		.o_row_long(o_row_long), .o_frame_index(o_frame_index));
	hdres_properties u_hdres_properties (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .reg_addr(link.reg_addr),
		.reg_re(link.reg_re), .reg_rdata(link.reg_rdata), .o_even_expose(o_even_expose),
		.o_clamp_on(o_clamp_on), .o_readout(o_readout), .o_frame_index(o_frame_index));

	// Master clock
	initial
	begin
		i_ref_clk = 1'b0;
		forever #50 i_ref_clk = ~i_ref_clk;
	end

	// Verdict and end of run
	task automatic wrap_up(input bit hang);
		if (hang)
			bad_count++;
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// One-cycle write and read strobes on the software port
	task automatic hw(input logic [2:0] a, input logic [15:0] x);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= x;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : hw

	task automatic hr(input logic [2:0] a, output logic [15:0] x);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		x = o_rdata;
	endtask : hr

	// Sequencer byte write, and read through the status word
	task automatic sw(input logic [6:0] a, input logic [7:0] x);
		hw(H_ADDR, {9'h000, a});
		hw(H_WR, {8'h00, x});
	endtask : sw

	task automatic sr(input logic [6:0] a, output logic [7:0] x);
		logic [15:0] s;
		hw(H_ADDR, {9'h000, a});
		hw(H_RD, 16'h0000);
		repeat (3) @(posedge i_ref_clk);
		hr(H_STAT, s);
		check("read valid", 16'h0001, {15'h0000, s[8]});
		x = s[7:0];
	endtask : sr

	task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] x;
		sr(a, x);
		check($sformatf("byte %h", a), {8'h00, e}, {8'h00, x});
	endtask : chk_rd

	// Bounded waits for a monitored output to rise, then its high width
	task automatic wait_hi(input int k);
		int n;
		n = 0;
		while (mon[k] !== 1'b1)
		begin
			@(posedge i_ref_clk);
			#1;
			n++;
			if (n > 9000)
				wrap_up(1'b1);
		end
	endtask : wait_hi

	task automatic measure(input int k, output int w);
		w = 0;
		wait_hi(k);
		while (mon[k] === 1'b1)
		begin
			@(posedge i_ref_clk);
			#1;
			w++;
			if (w > 9000)
				wrap_up(1'b1);
		end
	endtask : measure

	// Frame request pulse on the pin word
	task automatic req;
		hw(H_PINS, 16'h0001);
		hw(H_PINS, 16'h0000);
	endtask : req

	function automatic logic [15:0] expw(input int u);
		return 16'(55 + 129 * u + 1);
	endfunction : expw

	initial
	begin
		i_resetn = 1'b0;
		i_clk_en = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 3'h0;
		i_wdata = 16'h0000;
		bad_count = 0;
		checks = 0;
		repeat (4) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		// Defaults and unmapped byte
		foreach (rst_tab[i])
			chk_rd(rst_tab[i][14:8], rst_tab[i][7:0]);
		// Unwritable bits
		sw(A_CL2, 8'hFF);
		chk_rd(A_CL2, 8'h7F);
		sw(7'h3B, 8'hFF);
		chk_rd(7'h3B, 8'h00);
		sw(A_FOT, 8'h01);
		sw(A_PRI, 8'h02);
		sw(A_PRI + 7'h1, 8'h00);
		// Plain frame: both row sets share the primary time
		req();
		fork
			measure(0, w0);
			measure(1, w1);
		join
		check("even width", expw(2), 16'(w0));
		check("odd width", expw(2), 16'(w1));
		measure(3, w2);
		// Interleaved colour frame with a shorter secondary time
		sw(A_MODE, 8'h02);
		sw(A_MONO, 8'h00);
		sw(A_SEC, 8'h01);
		sw(A_SEC + 7'h1, 8'h00);
		req();
		fork
			measure(0, w0);
			measure(1, w1);
		join
		check("even width", expw(2), 16'(w0));
		check("odd width", expw(1), 16'(w1));
		// Colour rows pair up: row 5 on the primary time, row 6 on the shorter secondary
		wait_hi(3);
		repeat (5) @(posedge i_ref_clk);
		#1;
		check("row five", 16'h0005, {4'h0, o_row_long, o_row_index});
		@(posedge i_ref_clk);
		#1;
		check("row six", 16'h0806, {4'h0, o_row_long, o_row_index});
		measure(3, w2);
		// Piecewise with interleave is turned away
		sw(A_SLOPE, 8'h02);
		hr(H_STAT, v);
		check("refused", 16'h0001, {15'h0000, v[9]});
		chk_rd(A_SLOPE, 8'h01);
		hw(H_STAT, 16'h0000);
		hr(H_STAT, v);
		check("refused cleared", 16'h0000, {15'h0000, v[9]});
		// Two slopes, first clamp at code 5
		sw(A_MODE, 8'h00);
		sw(A_SLOPE, 8'h02);
		sw(A_CL2, 8'h45);
		req();
		fork
			measure(0, w0);
			measure(2, w1);
			begin
				wait_hi(2);
				check("clamp code", 16'h0005, {10'h000, o_clamp_code});
			end
		join
		check("total width", expw(2), 16'(w0));
		check("knee width", expw(1), 16'(w1));
		measure(3, w2);
		// Three slopes: second clamp follows the first and is cut at exposure end
		sw(A_SLOPE, 8'h03);
		req();
		wait_hi(2);
		repeat (200) @(posedge i_ref_clk);
		#1;
		check("second clamp code", {10'h000, R_CL[5:0]}, {10'h000, o_clamp_code});
		measure(2, w1);
		check("clamp tail", expw(2) - 16'd200, 16'(w1));
		measure(3, w2);
		// Burst of two frames, step one unit
		sw(A_SLOPE, 8'h01);
		sw(A_STEP, 8'h01);
		sw(A_NFRM, 8'h02);
		req();
		measure(0, w0);
		check("frame one width", expw(2), 16'(w0));
		measure(0, w1);
		check("frame two width", expw(3), 16'(w1));
		check("frame index", 16'h0002, {8'h00, o_frame_index});
		measure(3, w2);
		// Pin timing refused while a burst is set
		sw(A_MODE, 8'h01);
		chk_rd(A_MODE, 8'h00);
		hw(H_STAT, 16'h0000);
		// Pin-timed interleaved exposure: pin one opens even rows, pin two odd rows
		sw(A_NFRM, 8'h01);
		sw(A_MODE, 8'h03);
		hw(H_PINS, 16'h0002);
		repeat (20) @(posedge i_ref_clk);
		#1;
		check("pin expose", 16'h0001, {15'h0000, o_even_expose});
		check("odd before pin two", 16'h0000, {15'h0000, o_odd_expose});
		hw(H_PINS, 16'h0006);
		repeat (20) @(posedge i_ref_clk);
		#1;
		check("odd after pin two", 16'h0001, {15'h0000, o_odd_expose});
		hw(H_PINS, 16'h0007);
		measure(3, w2);
		check("pin expose end", 16'h0000, {15'h0000, o_even_expose});
		hw(H_PINS, 16'h0000);
		wrap_up(1'b0);
	end
endmodule : hdr_exposure_sequencer_tb
